/* File: rtl/link_controller.sv */
// byte link controller: register slave, pulse-width symbol engine, shared port
`timescale 1ns/1ps
`include "link_defs.svh"
module link_controller
    import link_pkg::*;
#(
    parameter int PORT_W    = 7,
    parameter int CNT_W     = 16,
    parameter int SHORT_CYC = `US_CYC(`SHORT_US),
    parameter int LONG_CYC  = `US_CYC(`LONG_US),
    parameter int SOF_CYC   = `US_CYC(`SOF_US),
    parameter int EOF_CYC   = `US_CYC(`EOF_US)
) (
    // clock, reset, enable
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              ce,
    input  wire logic              special_mode,
    // avalon-mm slave
    input  wire logic [2:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [3:0]        avs_byteenable,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // shared port pins, bit 0 receive, bit 1 transmit
    input  wire logic [PORT_W-1:0] port_in,
    output logic      [PORT_W-1:0] port_out,
    output logic      [PORT_W-1:0] port_oe,
    output logic                   pullup_en,
    output logic                   reduced_drive
);
    localparam logic [CNT_W-1:0] SHORT_L  = CNT_W'(SHORT_CYC);
    localparam logic [CNT_W-1:0] LONG_L   = CNT_W'(LONG_CYC);
    localparam logic [CNT_W-1:0] SOF_L    = CNT_W'(SOF_CYC);
    localparam logic [CNT_W-1:0] EOF_L    = CNT_W'(EOF_CYC);
    localparam logic [CNT_W-1:0] LONG_THR = CNT_W'((SHORT_CYC + LONG_CYC) / 2);
    localparam logic [CNT_W-1:0] SOF_THR  = CNT_W'((LONG_CYC + SOF_CYC) / 2);

    flags_if f ();

    vector_flags u_flags (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .f     (f)
    );

    function automatic logic [8:1] src_bit(input logic [3:0] c);
        src_bit = 8'h00;
        for (int i = 1; i <= 8; i++) begin
            if (c == 4'(i)) begin
                src_bit[i] = 1'b1;
            end
        end
    endfunction : src_bit

    // --------------------------------------------------------------------
    // bus slave: one wait cycle, read data latched before the answer
    // --------------------------------------------------------------------
    logic ack;
    logic [3:0] rep_code;
    wire req     = avs_read | avs_write;
    wire rd_take = avs_read & ack & ce;
    wire wr_take = avs_write & ack & ce & avs_byteenable[0];
    wire rd_vec  = rd_take & (avs_address == `OFF_VECTOR);
    wire rd_data = rd_take & (avs_address == `OFF_DATA);
    wire [7:0] wbyte = avs_writedata[7:0];
    function automatic logic wr_at(input logic [2:0] a, input logic take, input logic [2:0] adr);
        wr_at = take & (adr == a);
    endfunction : wr_at
    wire wr_data = wr_at(`OFF_DATA, wr_take, avs_address);
    wire wr_rt   = wr_at(`OFF_RTDELAY, wr_take, avs_address);
    wire wr_pc   = wr_at(`OFF_PORTCTL, wr_take, avs_address);
    wire wr_pd   = wr_at(`OFF_PORTDAT, wr_take, avs_address);
    wire wr_dir  = wr_at(`OFF_PORTDIR, wr_take, avs_address);
    wire wr_lc   = wr_at(`OFF_LINKCTL, wr_take, avs_address);

    assign avs_waitrequest = req & ~ack;

    // --------------------------------------------------------------------
    // software registers
    // --------------------------------------------------------------------
    logic [7:0]        rt_cfg;
    logic              rt_done;
    logic [2:0]        pc;
    logic [PORT_W-1:0] latch;
    logic [PORT_W-1:0] dir;
    logic [1:0]        loops;
    logic              eod_req;
    logic [7:0]        tshadow;
    logic              shadow_full;
    logic [7:0]        rx_byte;
    logic [PORT_W-1:0] pin_s1;
    logic [PORT_W-1:0] pin_s;
    logic [3:0]        armed;
    logic              lock;

    wire link_on = pc[`PC_LINK_EN];
    wire loop    = |loops;
    wire rt_ok   = wr_rt & (~rt_done | special_mode);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rt_cfg  <= `RT_RESET;
            rt_done <= 1'b0;
            pc      <= `PC_RESET;
            latch   <= `PORT_RESET;
            dir     <= `PORT_RESET;
            loops   <= 2'b00;
        end else if (ce) begin
            if (rt_ok) begin
                rt_cfg  <= wbyte;
                rt_done <= 1'b1;
            end
            if (wr_pc) pc <= wbyte[2:0];
            if (wr_pd) latch <= wbyte[PORT_W-1:0];
            if (wr_dir) dir <= wbyte[PORT_W-1:0];
            if (wr_lc) loops <= {wbyte[`LC_ANALOG_LOOPBACK], wbyte[`LC_DIGITAL_LOOPBACK]};
        end
    end

    // --------------------------------------------------------------------
    // read mux
    // --------------------------------------------------------------------
    wire [PORT_W-1:0] port_rd = (dir & latch) | (~dir & pin_s);
    wire [7:0] lc_rd  = {5'h00, eod_req, loops};
    wire [7:0] vec_rd = {2'b00, f.code, 2'b00};
    wire [7:0] rd_mux =
        (avs_address == `OFF_VECTOR)  ? vec_rd :
        (avs_address == `OFF_DATA)    ? rx_byte :
        (avs_address == `OFF_RTDELAY) ? rt_cfg :
        (avs_address == `OFF_PORTCTL) ? {5'h00, pc} :
        (avs_address == `OFF_PORTDAT) ? {1'b0, port_rd} :
        (avs_address == `OFF_PORTDIR) ? {1'b0, dir} :
        (avs_address == `OFF_LINKCTL) ? lc_rd : 8'h00;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack          <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            rep_code     <= 4'h0;
        end else if (ce) begin
            ack <= req & ~ack;
            if (req & ~ack) begin
                avs_readdata <= {24'h00_0000, rd_mux};
                rep_code     <= f.code;
            end
        end
    end

    // --------------------------------------------------------------------
    // pin sampling and receive line selection
    // --------------------------------------------------------------------
    logic tlvl;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // receive pin idles high behind an inverting transceiver; start there, no false edge
            pin_s1 <= '1;
            pin_s  <= '1;
        end else if (ce) begin
            pin_s1 <= port_in;
            pin_s  <= pin_s1;
        end
    end

    // loopback feeds our own level back, the bus pin is ignored
    wire rx_true = rt_cfg[`RT_RX_POL] ? pin_s[0] : ~pin_s[0];
    wire rx_line = loop ? tlvl : rx_true;

    // --------------------------------------------------------------------
    // receiver
    // --------------------------------------------------------------------
    logic             rx_d;
    logic [CNT_W-1:0] wcnt;
    logic             in_frame;
    logic             after_eod;
    logic [2:0]       rbits;
    logic [6:0]       rsh;
    logic [7:0]       sum;

    wire       ev_en    = link_on & ~lock;
    wire       rx_edge  = rx_line ^ rx_d;
    wire       sof_sym  = rx_edge & rx_d & (wcnt >= SOF_THR);
    wire       data_sym = rx_edge & in_frame & ~sof_sym;
    wire       rx_bit   = rx_d ^ (wcnt >= LONG_THR);
    wire       byte_done = data_sym & (rbits == 3'h7);
    wire [7:0] new_byte = {rsh, rx_bit};
    wire       eod_pt   = in_frame & ~rx_line & (wcnt == SOF_THR);
    wire       eof_pt   = in_frame & ~rx_line & (wcnt == EOF_L - 1'b1);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_d <= 1'b0;
            wcnt <= '0;
        end else if (ce) begin
            rx_d <= rx_line;
            wcnt <= rx_edge ? '0 : ((wcnt == EOF_L) ? wcnt : wcnt + 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            in_frame  <= 1'b0;
            after_eod <= 1'b0;
            rbits     <= 3'h0;
            rsh       <= 7'h00;
            sum       <= 8'h00;
            rx_byte   <= 8'h00;
        end else if (ce) begin
            if (!link_on || eof_pt) begin
                in_frame  <= 1'b0;
                after_eod <= 1'b0;
            end else if (sof_sym) begin
                in_frame  <= 1'b1;
                after_eod <= 1'b0;
                rbits     <= 3'h0;
                sum       <= 8'h00;
            end else if (data_sym) begin
                rsh   <= new_byte[6:0];
                rbits <= rbits + 3'h1;
                if (byte_done) begin
                    sum <= sum ^ new_byte;
                    if (ev_en) rx_byte <= new_byte;
                end
            end else if (eod_pt) begin
                after_eod <= 1'b1;
                rbits     <= 3'h0;
            end
        end
    end

    // --------------------------------------------------------------------
    // transmitter
    // --------------------------------------------------------------------
    tx_state_e        tx_st;
    logic [CNT_W-1:0] tcnt;
    logic [2:0]       tbit;
    logic [7:0]       tsh;
    logic             first_bit;

    wire [CNT_W-1:0] delay_cyc =
        CNT_W'((`DELAY_BASE_US + int'(rt_cfg[3:0])) * `US_CYC(1));
    wire tx_cur   = (tx_st == tx_extra) ? 1'b1 : tsh[7];
    wire [CNT_W-1:0] sym_len = (tx_st == tx_sof) ? SOF_L :
                               ((tx_cur ^ tlvl) ? LONG_L : SHORT_L);
    wire sym_end  = (tx_st != tx_idle) & (tcnt == sym_len - 1'b1);
    // a passive symbol that reads active after the echo delay lost the bus
    wire arb_lost = (tx_st != tx_idle) & ~tlvl & rx_line & (tcnt >= delay_cyc);
    wire tx_start = (tx_st == tx_idle) & shadow_full & link_on & ~lock & ~in_frame;
    wire byte_end = (tx_st == tx_bits) & sym_end & (tbit == 3'h7) & ~arb_lost;
    wire transmit_empty_flag_ev  = (tx_st == tx_bits) & sym_end & first_bit & ~arb_lost;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_st     <= tx_idle;
            tcnt      <= '0;
            tbit      <= 3'h0;
            tsh       <= 8'h00;
            tlvl      <= 1'b0;
            first_bit <= 1'b0;
        end else if (ce) begin
            tcnt <= (tx_start | sym_end | arb_lost) ? '0 : tcnt + 1'b1;
            unique case (tx_st)
                tx_idle: if (tx_start) begin
                    tx_st     <= tx_sof;
                    tlvl      <= 1'b1;
                    tsh       <= tshadow;
                    first_bit <= 1'b1;
                end
                tx_sof: if (sym_end) begin
                    tx_st <= tx_bits;
                    tlvl  <= 1'b0;
                    tbit  <= 3'h0;
                end
                tx_bits: if (arb_lost) begin
                    tx_st <= tx_idle;
                    tlvl  <= 1'b0;
                end else if (sym_end) begin
                    tlvl      <= ~tlvl;
                    tsh       <= {tsh[6:0], 1'b0};
                    tbit      <= tbit + 3'h1;
                    first_bit <= 1'b0;
                    if (tbit == 3'h7) begin
                        if (shadow_full) begin
                            tsh       <= tshadow;
                            first_bit <= 1'b1;
                        end else if (eod_req) begin
                            tx_st <= tx_idle;
                        end else begin
                            tx_st <= tx_extra;
                            tbit  <= 3'h0;
                        end
                    end
                end
                tx_extra: if (arb_lost || (sym_end && tbit == 3'h1)) begin
                    tx_st <= tx_idle;
                    tlvl  <= 1'b0;
                end else if (sym_end) begin
                    tlvl <= ~tlvl;
                    tbit <= tbit + 3'h1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tshadow     <= 8'h00;
            shadow_full <= 1'b0;
            eod_req     <= 1'b0;
        end else if (ce) begin
            if (wr_data) tshadow <= wbyte;
            shadow_full <= wr_data | (shadow_full & ~tx_start & ~byte_end);
            if (wr_lc && wbyte[`LC_EOD]) eod_req <= 1'b1;
            else if (byte_end && !shadow_full) eod_req <= 1'b0;
        end
    end

    // --------------------------------------------------------------------
    // source flags and their clearing
    // --------------------------------------------------------------------
    wire rep_buf  = (rep_code == src_ifr) | (rep_code == src_full) | (rep_code == src_empty);
    wire vec_clr  = rd_vec & ~rep_buf;
    wire rx_serve = rd_data & ((armed == src_ifr) | (armed == src_full));
    wire tx_serve = wr_data & (armed == src_empty);
    wire eod_clr  = wr_lc & wbyte[`LC_EOD];

    assign f.set = {~link_on & rx_edge,
                    ev_en & eod_pt & (rbits != 3'h0),
                    ev_en & eof_pt & (sum != 8'h00),
                    arb_lost,
                    transmit_empty_flag_ev,
                    ev_en & byte_done & ~after_eod,
                    ev_en & byte_done & after_eod,
                    ev_en & eof_pt};
    assign f.clr = (vec_clr ? src_bit(rep_code) : 8'h00)
                 | ((rx_serve | tx_serve) ? src_bit(armed) : 8'h00)
                 | (eod_clr ? src_bit(src_empty) : 8'h00);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            armed <= 4'h0;
            lock  <= 1'b0;
        end else if (ce) begin
            if (rd_vec && rep_buf) armed <= rep_code;
            else if (rx_serve || tx_serve) armed <= 4'h0;
            if (vec_clr && rep_code == src_inval) lock <= 1'b1;
            else if (eof_pt) lock <= 1'b0;
        end
    end

    // --------------------------------------------------------------------
    // shared port pins
    // --------------------------------------------------------------------
    // the transmit pin rests passive while looped so the bus sees nothing
    wire tx_pin = tlvl & ~loop;
    wire [PORT_W-1:0] next_port_out = link_on ? {latch[PORT_W-1:2], tx_pin, latch[0]} : latch;
    wire [PORT_W-1:0] next_port_oe  = link_on ? {dir[PORT_W-1:2], 2'b10} : dir;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            port_out <= '0;
            port_oe  <= '0;
        end else if (ce) begin
            port_out <= next_port_out;
            port_oe  <= next_port_oe;
        end
    end

    assign pullup_en     = pc[`PC_PULLUP];
    assign reduced_drive = pc[`PC_RDRIVE];

    // --------------------------------------------------------------------
    // checks
    // --------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_rx_served;
        rx_serve && armed == src_full && !f.set[3];
    endsequence
    sequence s_vec_plain;
        rd_vec && rep_code == src_eof && !f.set[1];
    endsequence

    a_vec_pad_zero: assert property (rd_vec |-> avs_readdata[31:6] == 26'h0 && avs_readdata[1:0] == 2'h0)
        else $error("vector bits outside code not zero");
    a_vec_read_clr: assert property (s_vec_plain |=> !f.pend[1])
        else $error("vector read did not clear end-of-frame");
    a_vec_keep_full: assert property (rd_vec && rep_code == src_full |=> f.pend[3])
        else $error("receive full cleared by vector read alone");
    a_rx_clr_served: assert property (s_rx_served |=> !f.pend[3])
        else $error("receive full not cleared by data read");
    a_eod_clr_empty: assert property (eod_clr && !f.set[4] |=> !f.pend[4])
        else $error("end request did not clear transmit empty");
    a_lock_no_tx: assert property (lock && tx_st == tx_idle && ce |=> tx_st == tx_idle)
        else $error("transmit started while locked");
    a_loop_quiet: assert property (loop && link_on && ce |=> !port_out[1])
        else $error("looped node drove the bus");
    a_rt_once: assert property (rt_done && !special_mode |=> $stable(rt_cfg))
        else $error("delay register rewritten");
    a_transmit_empty_flag_first_bit: assert property (transmit_empty_flag_ev |-> tx_st == tx_bits && tbit == 3'h0)
        else $error("transmit empty not after first bit");
    a_underrun_extra: assert property (byte_end && !shadow_full && !eod_req && ce |=> tx_st == tx_extra)
        else $error("underrun did not send extra ones");
    a_link_pins: assert property (link_on && $past(link_on) && $past(ce) |-> !port_oe[0] && port_oe[1])
        else $error("link pins not owned by link");

endmodule : link_controller

/* File: rtl/link_defs.svh */
// register offsets, field positions, reset values and timing figures
`ifndef LINK_DEFS_SVH
`define LINK_DEFS_SVH

// --------------------------------------------------------------------
// word offsets on the register bus
// --------------------------------------------------------------------
`define OFF_VECTOR   3'h0
`define OFF_DATA     3'h1
`define OFF_RTDELAY  3'h2
`define OFF_PORTCTL  3'h3
`define OFF_PORTDAT  3'h4
`define OFF_PORTDIR  3'h5
`define OFF_LINKCTL  3'h6

// --------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------
`define RT_XCVR_SEL  7
`define RT_RX_POL    6
`define PC_LINK_EN   2
`define PC_PULLUP    1
`define PC_RDRIVE    0
`define LC_DIGITAL_LOOPBACK     0
`define LC_ANALOG_LOOPBACK     1
`define LC_EOD       2

// --------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------
`define RT_RESET     8'h00
`define PC_RESET     3'h0
`define PORT_RESET   7'h00

// --------------------------------------------------------------------
// timing, in microseconds, and the clock period
// --------------------------------------------------------------------
`define CLK_PERIOD_PS 5000
`define SHORT_US      64
`define LONG_US       128
`define SOF_US        200
`define EOF_US        280
`define DELAY_BASE_US 9
`define US_CYC(us)    ((us) * 1000000 / `CLK_PERIOD_PS)

`endif

/* File: rtl/link_pkg.sv */
// types shared by the link controller files
package link_pkg;

    typedef enum logic [3:0] {
        src_none  = 4'b0000,
        src_eof   = 4'b0001,
        src_ifr   = 4'b0010,
        src_full  = 4'b0011,
        src_empty = 4'b0100,
        src_arb   = 4'b0101,
        src_crc   = 4'b0110,
        src_inval = 4'b0111,
        src_wake  = 4'b1000
    } src_e;

    typedef enum logic [1:0] {
        tx_idle  = 2'b00,
        tx_sof   = 2'b01,
        tx_bits  = 2'b10,
        tx_extra = 2'b11
    } tx_state_e;

endpackage : link_pkg

/* File: rtl/flags_if.sv */
// sticky source flags between the controller and its vector encoder
`timescale 1ns/1ps
interface flags_if;
    logic [8:1] set;
    logic [8:1] clr;
    logic [8:1] pend;
    logic [3:0] code;
    modport owner (input set, input clr, output pend, output code);
    modport user  (output set, output clr, input pend, input code);
endinterface : flags_if

/* File: rtl/vector_flags.sv */
// sticky pending sources and their priority code
`timescale 1ns/1ps
module vector_flags
    import link_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    // flag traffic
    flags_if.owner    f
);
    logic [8:1] pend;

    function automatic logic [3:0] highest(input logic [8:1] p);
        highest = 4'h0;
        for (int i = 1; i <= 8; i++) begin
            if (p[i]) begin
                highest = 4'(i);
            end
        end
    endfunction : highest

    // a set in the same cycle as its clear is kept
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pend <= 8'h00;
        end else if (ce) begin
            pend <= (pend & ~f.clr) | f.set;
        end
    end

    assign f.pend = pend;
    assign f.code = highest(pend);

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_code_highest: assert property (pend[8] |-> f.code == 4'h8)
        else $error("wakeup pending but not reported");
    a_code_none: assert property (pend == 8'h00 |-> f.code == 4'h0)
        else $error("empty vector not zero");
    a_code_next: assert property (pend[8:6] == 3'b001 |-> f.code == 4'h6)
        else $error("lower source not shown after higher cleared");

endmodule : vector_flags

/* File: testbench/bus_model.sv */
// far-side partner: pins read back own drive, pullups or a wandering float
`timescale 1ns/1ps
module bus_model (
    // pins
    input  wire logic       clk,
    input  wire logic [6:0] port_out,
    input  wire logic [6:0] port_oe,
    input  wire logic       pullup_en,
    input  wire logic [6:0] pull_low,
    output logic      [6:0] port_in
);
    logic [6:0] float_lvl = 7'h00;
    // unpulled, undriven pins toggle so no stale level reads as valid
    always @(posedge clk) float_lvl <= ~float_lvl;
    // receive pin comes from an inverting transceiver that echoes the bus;
    // pull_low[0] stands for another node driving the bus active
    wire       bus_act = (port_oe[1] & port_out[1]) | pull_low[0];
    wire [6:0] pad     = (port_oe & port_out)
                       | (~port_oe & ~pull_low & (pullup_en ? 7'h7F : float_lvl));
    assign port_in = {pad[6:1], ~bus_act};
endmodule : bus_model

/* File: testbench/link_controller_tb.sv */
// register-level tests of the link controller
`timescale 1ns/1ps
module link_controller_tb;
    logic clk = 0, rst_b = 0, rd = 0, wr = 0, special_mode = 0, ce = 1;
    logic [3:0] ben = 4'hF;
    logic [2:0] adr = 3'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic [6:0] pin_in, pout, poe, pull_low = 7'h00;
    logic wait_rq, pull, rdrv;
    logic [7:0] q;
    int mismatches = 0, tests_run = 0;
    always #2.5 clk = ~clk;
    link_controller #(.SHORT_CYC(8), .LONG_CYC(16), .SOF_CYC(26), .EOF_CYC(36)) i_link_controller (
        .clk(clk), .rst_b(rst_b), .ce(ce), .special_mode(special_mode),
        .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_byteenable(ben),
        .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wait_rq),
        .port_in(pin_in), .port_out(pout), .port_oe(poe), .pullup_en(pull), .reduced_drive(rdrv));
    bus_model i_bus_model (.clk(clk), .port_out(pout), .port_oe(poe), .pullup_en(pull),
        .pull_low(pull_low), .port_in(pin_in));
    // --------------------------------------------------------------------
    // bus tasks
    // --------------------------------------------------------------------
    // waits as long as the slave needs; only the watchdog ends a hung access
    task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        rd <= !w; wr <= w; adr <= a; wdat <= {24'h0, d};
        do @(posedge clk); while (wait_rq !== 1'b0);
        q = rdat[7:0];
        rd <= 1'b0; wr <= 1'b0;
    endtask : acc
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin mismatches++; $display("BAD %s exp %h got %h", nm, e, g); end
    endtask : chk
    task automatic rck(input logic [2:0] a, input logic [7:0] e);
        acc(0, a, 8'h00); chk($sformatf("reg%0d", a), e, q);
    endtask : rck
    // polling re-reads only while nothing is pending, so no code is lost
    task automatic poll(input logic [7:0] e);
        do acc(0, 3'h0, 8'h00); while (q == 8'h00);
        chk("vector", e, q);
    endtask : poll
    task automatic stop_test;
        if (mismatches == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : stop_test
    initial begin #100000; mismatches++; stop_test(); end
    // --------------------------------------------------------------------
    // tests
    // --------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        chk("oe", 8'h00, {1'b0, poe});
        rck(3'h0, 8'h00);
        rck(3'h7, 8'h00);
        acc(1, 3'h3, 8'h03);
        @(posedge clk);
        chk("drv", 8'h03, {6'h0, pull, rdrv});
        acc(1, 3'h5, 8'h0C); acc(1, 3'h4, 8'h55);
        repeat (4) @(posedge clk);
        rck(3'h4, 8'h77);
        chk("pout", 8'h04, {1'b0, pout & poe});
        ben <= 4'hE; acc(1, 3'h4, 8'h00); ben <= 4'hF;
        rck(3'h4, 8'h77);
        acc(1, 3'h2, 8'h40); acc(1, 3'h2, 8'h4F);
        rck(3'h2, 8'h40);
        special_mode <= 1'b1;
        acc(1, 3'h2, 8'h41); rck(3'h2, 8'h41);
        acc(1, 3'h2, 8'h00); special_mode <= 1'b0;
        rck(3'h0, 8'h20);
        ce <= 1'b0; pull_low <= 7'h01; repeat (6) @(posedge clk);
        pull_low <= 7'h00; repeat (6) @(posedge clk); ce <= 1'b1;
        rck(3'h0, 8'h00);
        pull_low <= 7'h01; repeat (6) @(posedge clk);
        pull_low <= 7'h00; repeat (6) @(posedge clk);
        rck(3'h0, 8'h20);
        rck(3'h0, 8'h00);
        acc(1, 3'h3, 8'h07); acc(1, 3'h4, 8'h7F);
        chk("txpin", 8'h00, {7'h0, pout[1]});
        acc(1, 3'h6, 8'h02); acc(1, 3'h1, 8'hA5);
        poll(8'h10);
        rck(3'h0, 8'h10);
        acc(1, 3'h6, 8'h05);
        poll(8'h0C);
        rck(3'h1, 8'hA5);
        poll(8'h18);
        stop_test();
    end
endmodule : link_controller_tb
